// file: hdl/arf_top.sv
// Converter result formatter with reference control register.
// Contract
// - Repeat count one gives a 12-bit unsigned result refreshed after each conversion.
// - Result is readable as separate high and low byte registers.
// - Right-justified mode puts the code in the low twelve bits.
// - Left-justified mode puts the code in the upper twelve bits.
// - Bits not used by the current format read as zero.
// - Accumulated results update once, after the last conversion of a series.
// - Accumulation over 4, 8 or 16 samples, chosen by the repeat field.
// - The accumulated sum is the plain total of the samples.
// - Reference control bits 7:6 read zero and ignore writes.
// - With zero-tc enable clear, the bias turns on when a consumer asks.
// - Reference control lives at 0xD1 page 0x00 and resets to zero.
// - Temperature sensor enable bit turns the sensor off or on.
// - Analog bias enable bit turns the bias generator off or on.
`timescale 1ns/1ns
module arf_top (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_page,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  input  wire logic        conv_done,
  input  wire logic [11:0] conv_code,
  input  wire logic        ztc_request,
  output logic             ztc_bias_on,
  output logic             ref_level_high,
  output logic             ref_source_internal,
  output logic             temp_sensor_on,
  output logic             bias_on,
  output logic             ref_buffer_on
);
  arf_acc_if acc_link ();

  arf_accum #(
    .CODE_W (arf_pkg::CODE_W),
    .SUM_W  (arf_pkg::RESULT_W)
  ) u_accum (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .acc     (acc_link.acc)
  );

  logic [7:0]  ref_q, ref_d;
  logic [7:0]  ctl_q, ctl_d;
  logic [7:0]  cfg_q, cfg_d;
  logic [15:0] result_q, result_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        ztc_q, ztc_d;
  logic        on_page;
  logic        wr_ref, wr_ctl, wr_cfg;
  logic        ljst;
  arf_pkg::arf_rpt_e rpt;

  assign on_page = (sfr_page == arf_pkg::PAGE_MAIN);
  assign wr_ref  = sfr_wr && on_page && (sfr_addr == arf_pkg::ADDR_REF_CTRL);
  assign wr_ctl  = sfr_wr && on_page && (sfr_addr == arf_pkg::ADDR_CONV_CTL);
  assign wr_cfg  = sfr_wr && on_page && (sfr_addr == arf_pkg::ADDR_CONV_CFG);
  assign ljst    = ctl_q[arf_pkg::CTL_LJST_BIT];
  assign rpt     = arf_pkg::arf_rpt_e'(cfg_q[arf_pkg::CFG_RPT_LSB +: 2]);

  // A change of repeat count abandons the partial series.
  assign acc_link.sample_valid = conv_done;
  assign acc_link.sample_code  = conv_code;
  assign acc_link.rpt_sel      = rpt;
  assign acc_link.restart      = wr_cfg;

  // Register writes.
  always_comb begin
    ref_d = ref_q;
    ctl_d = ctl_q;
    cfg_d = cfg_q;
    if (wr_ref) begin
      ref_d = (ref_q & ~arf_pkg::REF_WR_MASK) | (sfr_wdata & arf_pkg::REF_WR_MASK);
    end
    if (wr_ctl) begin
      ctl_d = sfr_wdata;
    end
    if (wr_cfg) begin
      cfg_d = sfr_wdata & arf_pkg::CFG_WR_MASK;
    end
  end

  // Result formatting.
  always_comb begin
    result_d = result_q;
    if (acc_link.sum_valid) begin
      if (rpt == arf_pkg::ARF_RPT_1 && ljst) begin
        result_d = {acc_link.sum[11:0], 4'h0};
      end else if (rpt == arf_pkg::ARF_RPT_1) begin
        result_d = {4'h0, acc_link.sum[11:0]};
      end else begin
        result_d = acc_link.sum;
      end
    end
  end

  // Read data and bias control.
  always_comb begin
    rdata_d = rdata_q;
    if (sfr_rd) begin
      rdata_d = 8'h00;
      if (on_page) begin
        unique case (sfr_addr)
          arf_pkg::ADDR_REF_CTRL: rdata_d = ref_q & arf_pkg::REF_RD_MASK;
          arf_pkg::ADDR_RES_HIGH: rdata_d = result_q[15:8];
          arf_pkg::ADDR_RES_LOW:  rdata_d = result_q[7:0];
          arf_pkg::ADDR_CONV_CTL: rdata_d = ctl_q;
          arf_pkg::ADDR_CONV_CFG: rdata_d = cfg_q;
          default:                rdata_d = 8'h00;
        endcase
      end
    end
    ztc_d = ref_q[arf_pkg::REF_ZTC_BIT] | ztc_request;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_q         <= arf_pkg::REF_CTRL_RST;
      ctl_q         <= arf_pkg::CONV_CTL_RST;
      cfg_q         <= arf_pkg::CONV_CFG_RST;
      result_q      <= arf_pkg::RESULT_RST;
      rdata_q       <= 8'h00;
      ztc_q         <= 1'b0;
    end else begin
      ref_q         <= ref_d;
      ctl_q         <= ctl_d;
      cfg_q         <= cfg_d;
      result_q      <= result_d;
      rdata_q       <= rdata_d;
      ztc_q         <= ztc_d;
    end
  end

  assign sfr_rdata           = rdata_q;
  assign ztc_bias_on         = ztc_q;
  assign ref_level_high      = ref_q[arf_pkg::REF_LVL_BIT];
  assign ref_source_internal = ref_q[arf_pkg::REF_SRC_BIT];
  assign temp_sensor_on      = ref_q[arf_pkg::REF_TEMP_BIT];
  assign bias_on             = ref_q[arf_pkg::REF_BIAS_BIT];
  assign ref_buffer_on       = ref_q[arf_pkg::REF_BUF_BIT];

  // Counts the samples taken since the last restart or reported sum, for the checks below.
  logic [4:0] seen_q, seen_d;
  logic [4:0] want_len;

  always_comb begin
    unique case (rpt)
      arf_pkg::ARF_RPT_1:  want_len = arf_pkg::RPT_LEN_1;
      arf_pkg::ARF_RPT_4:  want_len = arf_pkg::RPT_LEN_4;
      arf_pkg::ARF_RPT_8:  want_len = arf_pkg::RPT_LEN_8;
      arf_pkg::ARF_RPT_16: want_len = arf_pkg::RPT_LEN_16;
    endcase
  end

  always_comb begin
    seen_d = seen_q;
    if (acc_link.sum_valid) begin
      seen_d = 5'h00;
    end
    if (wr_cfg) begin
      seen_d = 5'h00;
    end else if (conv_done) begin
      seen_d = seen_d + 5'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_q <= 5'h00;
    end else begin
      seen_q <= seen_d;
    end
  end

  sequence s_single_right;
    conv_done && rpt == arf_pkg::ARF_RPT_1 && !ljst && !wr_ctl && !wr_cfg;
  endsequence

  sequence s_single_left;
    conv_done && rpt == arf_pkg::ARF_RPT_1 && ljst && !wr_ctl && !wr_cfg;
  endsequence

  property p_right_just;
    @(posedge sys_clk) disable iff (!rst_n)
      s_single_right ##1 !wr_ctl |=> result_q == {4'h0, $past(conv_code, 2)};
  endproperty
  a_right_just: assert property (p_right_just) else $error("right result wrong");

  property p_left_just;
    @(posedge sys_clk) disable iff (!rst_n)
      s_single_left ##1 !wr_ctl |=> result_q == {$past(conv_code, 2), 4'h0};
  endproperty
  a_left_just: assert property (p_left_just) else $error("left result wrong");

  property p_unused_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      s_single_right ##1 !wr_ctl |=> result_q[15:12] == 4'h0;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bits set");

  property p_each_refresh;
    @(posedge sys_clk) disable iff (!rst_n)
      s_single_right ##1 (!wr_ctl && !conv_done) ##1 !conv_done |=> $stable(result_q);
  endproperty
  a_each_refresh: assert property (p_each_refresh) else $error("result moved");

  property p_ref_reserved;
    @(posedge sys_clk) disable iff (!rst_n)
      sfr_rd && on_page && sfr_addr == arf_pkg::ADDR_REF_CTRL |=> sfr_rdata[7:6] == 2'b00;
  endproperty
  a_ref_reserved: assert property (p_ref_reserved) else $error("reserved bits read");

  property p_ref_page;
    @(posedge sys_clk) disable iff (!rst_n)
      sfr_wr && !on_page |=> $stable(ref_q);
  endproperty
  a_ref_page: assert property (p_ref_page) else $error("write off page took");

  property p_ztc_auto;
    @(posedge sys_clk) disable iff (!rst_n)
      ztc_request |=> ztc_bias_on;
  endproperty
  a_ztc_auto: assert property (p_ztc_auto) else $error("bias not started");

  property p_temp_bit;
    @(posedge sys_clk) disable iff (!rst_n)
      wr_ref |=> temp_sensor_on == $past(sfr_wdata[arf_pkg::REF_TEMP_BIT]);
  endproperty
  a_temp_bit: assert property (p_temp_bit) else $error("sensor enable wrong");

  property p_bias_bit;
    @(posedge sys_clk) disable iff (!rst_n)
      wr_ref |=> bias_on == $past(sfr_wdata[arf_pkg::REF_BIAS_BIT]);
  endproperty
  a_bias_bit: assert property (p_bias_bit) else $error("bias enable wrong");

  property p_readback_high;
    @(posedge sys_clk) disable iff (!rst_n)
      sfr_rd && on_page && sfr_addr == arf_pkg::ADDR_RES_HIGH |=>
        sfr_rdata == $past(result_q[15:8]);
  endproperty
  a_readback_high: assert property (p_readback_high) else $error("high byte wrong");

  sequence s_series_end;
    acc_link.sum_valid && rpt != arf_pkg::ARF_RPT_1;
  endsequence

  property p_series_len;
    @(posedge sys_clk) disable iff (!rst_n)
      acc_link.sum_valid |-> seen_q == want_len;
  endproperty
  a_series_len: assert property (p_series_len) else $error("series length wrong");

  property p_hold_result;
    @(posedge sys_clk) disable iff (!rst_n)
      !acc_link.sum_valid |=> $stable(result_q);
  endproperty
  a_hold_result: assert property (p_hold_result) else $error("result moved early");

  property p_accum_plain;
    @(posedge sys_clk) disable iff (!rst_n)
      s_series_end |=> result_q == $past(acc_link.sum);
  endproperty
  a_accum_plain: assert property (p_accum_plain) else $error("sum not reported");

  property p_four_unused;
    @(posedge sys_clk) disable iff (!rst_n)
      acc_link.sum_valid && rpt == arf_pkg::ARF_RPT_4 |=> result_q[15:14] == 2'h0;
  endproperty
  a_four_unused: assert property (p_four_unused) else $error("sum of four too wide");

  property p_eight_unused;
    @(posedge sys_clk) disable iff (!rst_n)
      acc_link.sum_valid && rpt == arf_pkg::ARF_RPT_8 |=> result_q[15] == 1'h0;
  endproperty
  a_eight_unused: assert property (p_eight_unused) else $error("sum of eight too wide");

  property p_left_low_zero;
    @(posedge sys_clk) disable iff (!rst_n)
      acc_link.sum_valid && rpt == arf_pkg::ARF_RPT_1 && ljst |=> result_q[3:0] == 4'h0;
  endproperty
  a_left_low_zero: assert property (p_left_low_zero) else $error("low nibble set");

  property p_ref_top_fixed;
    @(posedge sys_clk) disable iff (!rst_n)
      wr_ref |=> ref_q[7:4] == $past(ref_q[7:4]);
  endproperty
  a_ref_top_fixed: assert property (p_ref_top_fixed) else $error("fixed bits written");

  property p_ref_low_taken;
    @(posedge sys_clk) disable iff (!rst_n)
      wr_ref |=> ref_q[3:0] == $past(sfr_wdata[3:0]);
  endproperty
  a_ref_low_taken: assert property (p_ref_low_taken) else $error("write not taken");

  property p_ref_quiet;
    @(posedge sys_clk) disable iff (!rst_n)
      !wr_ref |=> $stable(ref_q);
  endproperty
  a_ref_quiet: assert property (p_ref_quiet) else $error("reference control moved");

  property p_offpage_read;
    @(posedge sys_clk) disable iff (!rst_n)
      sfr_rd && !on_page |=> sfr_rdata == 8'h00;
  endproperty
  a_offpage_read: assert property (p_offpage_read) else $error("off page read data");

  property p_readback_low;
    @(posedge sys_clk) disable iff (!rst_n)
      sfr_rd && on_page && sfr_addr == arf_pkg::ADDR_RES_LOW |=>
        sfr_rdata == $past(result_q[7:0]);
  endproperty
  a_readback_low: assert property (p_readback_low) else $error("low byte wrong");

  property p_ztc_idle;
    @(posedge sys_clk) disable iff (!rst_n)
      !ztc_request && !ref_q[arf_pkg::REF_ZTC_BIT] |=> !ztc_bias_on;
  endproperty
  a_ztc_idle: assert property (p_ztc_idle) else $error("bias on without need");
endmodule : arf_top

// file: hdl/arf_pkg.sv
// Package of constants for the converter result formatter.
package arf_pkg;
  localparam int unsigned CODE_W   = 12;
  localparam int unsigned RESULT_W = 16;

  // Register page and addresses on the special-function register port.
  localparam logic [7:0] PAGE_MAIN     = 8'h00;
  localparam logic [7:0] ADDR_REF_CTRL = 8'hD1;
  localparam logic [7:0] ADDR_RES_LOW  = 8'hBD;
  localparam logic [7:0] ADDR_RES_HIGH = 8'hBE;
  localparam logic [7:0] ADDR_CONV_CTL = 8'hE8;
  localparam logic [7:0] ADDR_CONV_CFG = 8'hBC;

  // Reset values.
  localparam logic [7:0]  REF_CTRL_RST = 8'h00;
  localparam logic [7:0]  CONV_CTL_RST = 8'h00;
  localparam logic [7:0]  CONV_CFG_RST = 8'h00;
  localparam logic [15:0] RESULT_RST   = 16'h0000;

  // Reference control field positions.
  localparam int unsigned REF_ZTC_BIT   = 5;
  localparam int unsigned REF_LVL_BIT   = 4;
  localparam int unsigned REF_SRC_BIT   = 3;
  localparam int unsigned REF_TEMP_BIT  = 2;
  localparam int unsigned REF_BIAS_BIT  = 1;
  localparam int unsigned REF_BUF_BIT   = 0;
  localparam logic [7:0]  REF_WR_MASK   = 8'h0F;
  localparam logic [7:0]  REF_RD_MASK   = 8'h3F;

  // Converter control and configuration field positions.
  localparam int unsigned CTL_LJST_BIT  = 2;
  localparam int unsigned CFG_RPT_LSB   = 1;
  localparam logic [7:0]  CFG_WR_MASK   = 8'h06;

  // Repeat count encodings.
  typedef enum logic [1:0] {
    ARF_RPT_1,
    ARF_RPT_4,
    ARF_RPT_8,
    ARF_RPT_16
  } arf_rpt_e;

  localparam logic [4:0] RPT_LEN_1  = 5'h01;
  localparam logic [4:0] RPT_LEN_4  = 5'h04;
  localparam logic [4:0] RPT_LEN_8  = 5'h08;
  localparam logic [4:0] RPT_LEN_16 = 5'h10;
endpackage : arf_pkg

// file: hdl/arf_acc_if.sv
// Interface between the formatter and its sample accumulator.
`timescale 1ns/1ns
interface arf_acc_if;
  logic                 sample_valid;
  logic [11:0]          sample_code;
  arf_pkg::arf_rpt_e    rpt_sel;
  logic                 restart;
  logic                 sum_valid;
  logic [15:0]          sum;

  modport fmt (output sample_valid, output sample_code, output rpt_sel, output restart,
               input sum_valid, input sum);
  modport acc (input sample_valid, input sample_code, input rpt_sel, input restart,
               output sum_valid, output sum);
endinterface : arf_acc_if

// file: hdl/arf_accum.sv
// Sample accumulator that sums a series of conversion codes.
`timescale 1ns/1ns
module arf_accum #(
  parameter int unsigned CODE_W = 12,
  parameter int unsigned SUM_W  = 16
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  arf_acc_if.acc    acc
);
  if (CODE_W + 4 > SUM_W || SUM_W != 16 || CODE_W != 12) begin : g_bad_width
    $error("arf_accum: widths not supported");
  end

  logic [4:0]       len;
  logic [4:0]       count_q, count_d;
  logic [SUM_W-1:0] acc_q, acc_d;
  logic [SUM_W-1:0] sum_q, sum_d;
  logic             valid_q, valid_d;
  logic [SUM_W-1:0] total;

  always_comb begin
    unique case (acc.rpt_sel)
      arf_pkg::ARF_RPT_1:  len = arf_pkg::RPT_LEN_1;
      arf_pkg::ARF_RPT_4:  len = arf_pkg::RPT_LEN_4;
      arf_pkg::ARF_RPT_8:  len = arf_pkg::RPT_LEN_8;
      arf_pkg::ARF_RPT_16: len = arf_pkg::RPT_LEN_16;
    endcase
  end

  always_comb begin
    total   = acc_q + SUM_W'(acc.sample_code);
    count_d = count_q;
    acc_d   = acc_q;
    sum_d   = sum_q;
    valid_d = 1'b0;
    if (acc.restart) begin
      count_d = '0;
      acc_d   = '0;
    end else if (acc.sample_valid) begin
      if (count_q + 5'd1 >= len) begin
        sum_d   = total;
        valid_d = 1'b1;
        count_d = '0;
        acc_d   = '0;
      end else begin
        count_d = count_q + 5'd1;
        acc_d   = total;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
      acc_q   <= '0;
      sum_q   <= '0;
      valid_q <= 1'b0;
    end else begin
      count_q <= count_d;
      acc_q   <= acc_d;
      sum_q   <= sum_d;
      valid_q <= valid_d;
    end
  end

  assign acc.sum_valid = valid_q;
  assign acc.sum       = sum_q;

  property p_no_early_sum;
    @(posedge sys_clk) disable iff (!rst_n)
      acc.sample_valid && !acc.restart && (count_q + 5'd1 < len) |=> !valid_q;
  endproperty
  a_no_early_sum: assert property (p_no_early_sum) else $error("sum before series end");

  property p_sum4_bound;
    @(posedge sys_clk) disable iff (!rst_n)
      valid_q && $past(acc.rpt_sel) == arf_pkg::ARF_RPT_4 |-> sum_q <= 16'h3FFC;
  endproperty
  a_sum4_bound: assert property (p_sum4_bound) else $error("sum of four too large");

  property p_restart_clears;
    @(posedge sys_clk) disable iff (!rst_n)
      acc.restart |=> count_q == 5'd0 && acc_q == '0;
  endproperty
  a_restart_clears: assert property (p_restart_clears) else $error("series not cleared");
endmodule : arf_accum

// file: test/arf_top_bench.sv
// Self-checking testbench for the converter result formatter.
`timescale 1ns/1ns
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module arf_top_bench;
  logic        sys_clk;
  logic        rst_n;
  logic [7:0]  sfr_addr;
  logic [7:0]  sfr_page;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_wdata;
  logic [7:0]  sfr_rdata;
  logic        conv_done;
  logic [11:0] conv_code;
  logic        ztc_request;
  logic        ztc_bias_on;
  logic        ref_level_high;
  logic        ref_source_internal;
  logic        temp_sensor_on;
  logic        bias_on;
  logic        ref_buffer_on;
  int          mismatches;
  int          checked;

  arf_top u_dut (
    .sys_clk             (sys_clk),
    .rst_n               (rst_n),
    .sfr_addr            (sfr_addr),
    .sfr_page            (sfr_page),
    .sfr_wr              (sfr_wr),
    .sfr_rd              (sfr_rd),
    .sfr_wdata           (sfr_wdata),
    .sfr_rdata           (sfr_rdata),
    .conv_done           (conv_done),
    .conv_code           (conv_code),
    .ztc_request         (ztc_request),
    .ztc_bias_on         (ztc_bias_on),
    .ref_level_high      (ref_level_high),
    .ref_source_internal (ref_source_internal),
    .temp_sensor_on      (temp_sensor_on),
    .bias_on             (bias_on),
    .ref_buffer_on       (ref_buffer_on)
  );

  always #5 sys_clk = ~sys_clk;

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    sfr_wr    <= 1'b1;
    sfr_addr  <= addr;
    sfr_wdata <= data;
    @(posedge sys_clk);
    sfr_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge sys_clk);
    sfr_rd   <= 1'b1;
    sfr_addr <= addr;
    @(posedge sys_clk);
    sfr_rd   <= 1'b0;
    #1;
    data = sfr_rdata;
  endtask : rd

  // Reads the high byte first, then the low byte, and compares the pair.
  task automatic chk_result(input logic [15:0] exp);
    logic [7:0] h;
    logic [7:0] l;
    rd(arf_pkg::ADDR_RES_HIGH, h);
    rd(arf_pkg::ADDR_RES_LOW, l);
    `CHK({h, l}, exp)
  endtask : chk_result

  task automatic conv(input logic [11:0] code);
    @(posedge sys_clk);
    conv_done <= 1'b1;
    conv_code <= code;
    @(posedge sys_clk);
    conv_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : conv

  task automatic t_ref_ctrl();
    logic [7:0] d;
    rd(arf_pkg::ADDR_REF_CTRL, d);
    `CHK(d, 8'h00)
    wr(arf_pkg::ADDR_REF_CTRL, 8'hFF);
    rd(arf_pkg::ADDR_REF_CTRL, d);
    `CHK(d, 8'h0F)
    `CHK({ref_level_high, ref_source_internal, ref_buffer_on}, 3'b011)
    `CHK(temp_sensor_on, 1'b1)
    `CHK(bias_on, 1'b1)
    @(posedge sys_clk);
    sfr_page <= 8'h01;
    rd(arf_pkg::ADDR_REF_CTRL, d);
    `CHK(d, 8'h00)
    wr(arf_pkg::ADDR_REF_CTRL, 8'h00);
    sfr_page <= 8'h00;
    rd(arf_pkg::ADDR_REF_CTRL, d);
    `CHK(d, 8'h0F)
    wr(arf_pkg::ADDR_REF_CTRL, 8'h00);
    repeat (2) @(posedge sys_clk);
    `CHK(temp_sensor_on, 1'b0)
    `CHK(bias_on, 1'b0)
    rd(8'h55, d);
    `CHK(d, 8'h00)
  endtask : t_ref_ctrl

  task automatic t_ztc();
    @(posedge sys_clk);
    ztc_request <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK(ztc_bias_on, 1'b1)
    ztc_request <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHK(ztc_bias_on, 1'b0)
  endtask : t_ztc

  task automatic t_single();
    wr(arf_pkg::ADDR_CONV_CFG, 8'h00);
    conv(12'hFFF);
    chk_result(16'h0FFF);
    conv(12'h800);
    chk_result(16'h0800);
    wr(arf_pkg::ADDR_CONV_CTL, 8'h04);
    conv(12'hFFF);
    chk_result(16'hFFF0);
    conv(12'h7FF);
    chk_result(16'h7FF0);
    wr(arf_pkg::ADDR_CONV_CTL, 8'h00);
    conv(12'h001);
    chk_result(16'h0001);
  endtask : t_single

  // Each series of the loop is checked before its last sample, then after it.
  task automatic t_accum();
    logic [15:0] prev;
    prev = 16'h0001;
    for (int s = 1; s <= 3; s++) begin
      wr(arf_pkg::ADDR_CONV_CFG, {5'h00, s[1:0], 1'b0});
      for (int i = 1; i < (2 << s); i++) begin
        conv(12'hFFF);
      end
      chk_result(prev);
      conv(12'hFFF);
      prev = 16'h0FFF << (s + 1);
      chk_result(prev);
    end
    wr(arf_pkg::ADDR_CONV_CFG, 8'h02);
    repeat (4) conv(12'h7FF);
    chk_result(16'h1FFC);
    conv(12'h800);
    conv(12'h800);
    wr(arf_pkg::ADDR_CONV_CFG, 8'h02);
    repeat (4) conv(12'h800);
    chk_result(16'h2000);
  endtask : t_accum

  // A reset in mid-run must return the reference control to zero.
  task automatic t_reset_mid();
    logic [7:0] d;
    wr(arf_pkg::ADDR_REF_CTRL, 8'h06);
    @(posedge sys_clk);
    `CHK({temp_sensor_on, bias_on}, 2'b11)
    rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    `CHK({temp_sensor_on, bias_on}, 2'b00)
    rd(arf_pkg::ADDR_REF_CTRL, d);
    `CHK(d, 8'h00)
  endtask : t_reset_mid

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    sys_clk     = 1'b0;
    rst_n       = 1'b0;
    sfr_addr    = 8'h00;
    sfr_page    = 8'h00;
    sfr_wr      = 1'b0;
    sfr_rd      = 1'b0;
    sfr_wdata   = 8'h00;
    conv_done   = 1'b0;
    conv_code   = 12'h000;
    ztc_request = 1'b0;
    mismatches  = 0;
    checked     = 0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_ref_ctrl();
    t_ztc();
    t_single();
    t_accum();
    t_reset_mid();
    wrap_up();
  end

  // The tests need a few hundred cycles; this limit cuts off a hang.
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
endmodule : arf_top_bench
